// ===== src/sef_pkg.sv
// Shared constants and types of the serial EEPROM bus front end.
// Assumes a 25 MHz system clock; all times become cycle counts here.
package sef_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned GLITCH_NS     = 50;
  // Least time, rounded up
  localparam int unsigned GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PU_READY_US   = 100; // 0.1 ms
  // Longest time, rounded down
  localparam int unsigned PU_CYC        = (PU_READY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROG_TIME_MS  = 5;
  localparam int unsigned PROG_CYC_DEF  = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PU_W          = 12;
  localparam int unsigned PROG_W        = 17;

  // ----------------------------------------
  // Protocol fields
  // ----------------------------------------
  localparam logic [3:0] SLAVE_PREFIX = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;
  localparam logic [1:0] BYTE_SLAVE   = 2'h0;
  localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
  localparam logic [1:0] BYTE_DATA    = 2'h3;

  // ----------------------------------------
  // Received byte buffer
  // ----------------------------------------
  localparam int unsigned RX_W     = 9;  // {is_data, byte}
  localparam int unsigned RX_DEPTH = 8;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RECV = 3'h1,
    S_ACK  = 3'h2,
    S_SEND = 3'h3,
    S_MACK = 3'h4
  } sef_state_t;

endpackage

// ===== src/sef_fifo.sv
// Shift-register FIFO; the head word always sits in the first slot.
// Assumes both sides run on the same clock.
`timescale 1ns/1ns
`default_nettype none

module sef_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned IW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             wr_rdy_r;
  logic             rd_vld_r;
  logic             push;
  logic             pop;
  logic [IW-1:0]    widx;

  assign push = i_wr_valid && wr_rdy_r;
  assign pop  = rd_vld_r && i_rd_ready;
  // Head is a flop, so the read side sees no comb path
  assign widx = IW'(cnt_r - CW'(pop));

  always_comb begin
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_nxt[i] = mem_r[i + 1];
      end
    end
    if (push) begin
      mem_nxt[widx] = i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_r    <= '0;
      wr_rdy_r <= 1'b1;
      rd_vld_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      cnt_r    <= cnt_nxt;
      wr_rdy_r <= (cnt_nxt != CW'(DEPTH));
      rd_vld_r <= (cnt_nxt != '0);
      mem_r    <= mem_nxt;
    end
  end

  assign o_wr_ready = wr_rdy_r;
  assign o_rd_valid = rd_vld_r;
  assign o_rd_data  = mem_r[0];

endmodule // sef_fifo

`default_nettype wire

// ===== src/sef_front.sv
// Two-wire bus front end of a serial EEPROM slave.
// Assumes the memory core drains received bytes, supplies read bytes and
// performs programming while busy; i_reset stands for power-on reset.
`timescale 1ns/1ns
`default_nettype none

// Operation
// RQ1 - Leaving reset, logic goes to standby with defined idle state.
// RQ2 - Reset abandons any bus transaction and returns to reset state.
// RQ3 - Commands accepted no later than 0.1 ms after reset release.
// RQ4 - Incoming data bits captured at serial clock rising edge.
// RQ5 - Transmit data changes only after a serial clock falling edge.
// RQ6 - Data pin open drain: pull low for zero, release for one.
// RQ7 - Write protect high blocks every memory write; reads unaffected.
// RQ8 - Undriven protect and select pins read as low.
// RQ9 - Pulses up to 50 ns on clock and data are ignored.
// RQ10 - Device select bits come from the two select pins.
// RQ11 - Master generates serial clock; device only receives it.
// RQ12 - Slave byte: prefix 1010, select bits, top address bit, direction.
// RQ13 - Matching slave address acknowledged by pulling data low on ninth clock.
// RQ14 - No slave address acknowledge while programming is in progress.
// RQ15 - Protect sampled before first data byte; high means nack and reject.
// RQ16 - After write stop, busy for program cycle time, then standby.
// RQ17 - Clock and data oversampled, synchronised and edge qualified.
module sef_front
  import sef_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYC_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  input  wire logic       i_wp,
  input  wire logic       i_device_select_bit_low,
  input  wire logic       i_device_select_bit_high,
  output logic            o_ready,
  output logic            o_busy,
  output logic            o_addr_match,
  output logic            o_read_mode,
  output logic            o_memory_address_top_bit,
  output logic            o_tx_req,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rx_valid,
  output logic [RX_W-1:0] o_rx_data,
  input  wire logic       i_rx_ready,
  output logic            o_prog_start,
  output logic            o_wp_reject
);

  // ----------------------------------------
  // Input synchronisers and glitch filter
  // ----------------------------------------
  logic [1:0] s1_r, s2_r, flt_r, flt_nxt, flt_q_r;
  logic [1:0] gcnt_r [2];
  logic [1:0] gcnt_nxt [2];
  logic [2:0] pin_s1_r, pin_s2_r;
  logic       scl_s2, scl_f;

  always_comb begin
    for (int g = 0; g < 2; g++) begin
      gcnt_nxt[g] = 2'h0;
      flt_nxt[g]  = flt_r[g];
      if (s2_r[g] != flt_r[g]) begin
        // Accept only after a level outlives the glitch width [RQ9]
        if (gcnt_r[g] == 2'(GLITCH_CYC)) begin
          flt_nxt[g] = s2_r[g];
        end else begin
          gcnt_nxt[g] = gcnt_r[g] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_r     <= 2'h3;
      s2_r     <= 2'h3;
      flt_r    <= 2'h3;
      flt_q_r  <= 2'h3;
      gcnt_r   <= '{2'h0, 2'h0};
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      s1_r     <= {i_sda, i_scl}; // Clock only sampled, never driven [RQ11] [RQ17]
      s2_r     <= s1_r;
      flt_r    <= flt_nxt;
      flt_q_r  <= flt_r;
      gcnt_r   <= gcnt_nxt;
      // Float counts as low, like the pull-downs [RQ8]
      pin_s1_r <= {i_wp === 1'b1,
                   i_device_select_bit_high === 1'b1,
                   i_device_select_bit_low === 1'b1};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign scl_s2 = s2_r[0];
  assign scl_f  = flt_r[0];

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic sda_f, wp_s;
  logic [1:0] sel_s;

  // Edges qualified on filtered levels only [RQ17]
  assign scl_rise = flt_r[0] && !flt_q_r[0];
  assign scl_fall = !flt_r[0] && flt_q_r[0];
  assign start_ev = flt_r[0] && flt_q_r[0] && flt_q_r[1] && !flt_r[1];
  assign stop_ev  = flt_r[0] && flt_q_r[0] && !flt_q_r[1] && flt_r[1];
  assign sda_f    = flt_r[1];
  assign wp_s     = pin_s2_r[2];
  assign sel_s    = pin_s2_r[1:0];

  // ----------------------------------------
  // Power-up delay and program cycle
  // ----------------------------------------
  logic [PU_W-1:0]   pu_cnt_r, pu_cnt_nxt;
  logic [PROG_W-1:0] prog_cnt_r, prog_cnt_nxt;
  logic              ready_r, ready_nxt, busy_r, busy_nxt;
  logic              go_prog;

  always_comb begin
    pu_cnt_nxt   = pu_cnt_r;
    ready_nxt    = ready_r;
    prog_cnt_nxt = prog_cnt_r;
    busy_nxt     = busy_r;
    if (pu_cnt_r == PU_W'(PU_CYC - 1)) begin
      ready_nxt = 1'b1; // [RQ3]
    end else begin
      pu_cnt_nxt = pu_cnt_r + PU_W'(1);
    end
    if (go_prog) begin
      busy_nxt     = 1'b1; // [RQ16]
      prog_cnt_nxt = '0;
    end else if (busy_r) begin
      if (prog_cnt_r == PROG_W'(PROG_CYC - 1)) begin
        busy_nxt = 1'b0;
      end else begin
        prog_cnt_nxt = prog_cnt_r + PROG_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  sef_state_t st_r, st_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [1:0] byte_idx_r, byte_idx_nxt;
  logic       rw_r, rw_nxt, top_r, top_nxt, wp_lat_r, wp_lat_nxt;
  logic       wrote_r, wrote_nxt, mack_r, mack_nxt;
  logic       oe_r, oe_nxt, match_r, match_nxt, txr_r, txr_nxt;
  logic       prog_r, rej_r, rej_nxt;
  logic       addr_ok, fifo_push, fifo_rdy, sda_o_r;

  // Prefix and select pins must both agree [RQ10] [RQ12]
  assign addr_ok = (sh_r[7:4] == SLAVE_PREFIX) && (sh_r[3:2] == sel_s);

  always_comb begin
    st_nxt       = st_r;
    bit_cnt_nxt  = bit_cnt_r;
    sh_nxt       = sh_r;
    byte_idx_nxt = byte_idx_r;
    rw_nxt       = rw_r;
    top_nxt      = top_r;
    wp_lat_nxt   = wp_lat_r;
    wrote_nxt    = wrote_r;
    mack_nxt     = mack_r;
    oe_nxt       = oe_r;
    match_nxt    = 1'b0;
    txr_nxt      = 1'b0;
    rej_nxt      = 1'b0;
    fifo_push    = 1'b0;
    go_prog      = 1'b0;
    if (stop_ev) begin
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
      // Rejected writes never set wrote_r [RQ7]
      go_prog = !rw_r && wrote_r && !wp_lat_r; // [RQ16]
      wrote_nxt = 1'b0;
    end else if (start_ev && ready_r) begin
      st_nxt       = S_RECV; // [RQ3]
      oe_nxt       = 1'b0;
      bit_cnt_nxt  = 4'h0;
      byte_idx_nxt = BYTE_SLAVE;
      wp_lat_nxt   = 1'b0;
      wrote_nxt    = 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
        end
        S_RECV: begin
          if (scl_rise) begin
            sh_nxt      = {sh_r[6:0], sda_f}; // [RQ4]
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            if (byte_idx_r == BYTE_SLAVE) begin
              if (addr_ok && !busy_r) begin // [RQ14]
                oe_nxt    = 1'b1; // [RQ13]
                st_nxt    = S_ACK;
                match_nxt = 1'b1;
                rw_nxt    = sh_r[0];
                top_nxt   = sh_r[1];
              end else begin
                st_nxt = S_IDLE;
              end
            end else if (byte_idx_r == BYTE_DATA && wp_lat_r) begin
              st_nxt  = S_IDLE; // [RQ15]
              rej_nxt = 1'b1;
            end else if (fifo_rdy) begin
              fifo_push = 1'b1;
              oe_nxt    = 1'b1;
              st_nxt    = S_ACK;
              wrote_nxt = wrote_r || (byte_idx_r == BYTE_DATA);
            end else begin
              // Full buffer refuses the byte by not acknowledging
              st_nxt = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            if (!rw_r && byte_idx_r == BYTE_ADDR_LO) begin
              wp_lat_nxt = wp_s; // [RQ15]
            end
            if (rw_r) begin
              st_nxt  = S_SEND;
              sh_nxt  = i_tx_data;
              txr_nxt = 1'b1;
              oe_nxt  = !i_tx_data[7]; // [RQ5] [RQ6]
            end else begin
              st_nxt = S_RECV;
              oe_nxt = 1'b0;
              if (byte_idx_r != BYTE_DATA) begin
                byte_idx_nxt = byte_idx_r + 2'h1;
              end
            end
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_r == LAST_TX_BIT) begin
              st_nxt = S_MACK;
              oe_nxt = 1'b0;
            end else begin
              sh_nxt      = {sh_r[6:0], 1'b0};
              oe_nxt      = !sh_r[6]; // [RQ5] [RQ6]
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            mack_nxt = !sda_f;
          end else if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            if (mack_r) begin
              st_nxt  = S_SEND;
              sh_nxt  = i_tx_data;
              txr_nxt = 1'b1;
              oe_nxt  = !i_tx_data[7]; // [RQ5]
            end else begin
              st_nxt = S_IDLE;
            end
          end
        end
        default: begin
          st_nxt = S_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Synchronous power-on reset drops everything, mid-frame too [RQ1] [RQ2]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pu_cnt_r   <= '0;
      ready_r    <= 1'b0;
      prog_cnt_r <= '0;
      busy_r     <= 1'b0;
      st_r       <= S_IDLE;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h00;
      byte_idx_r <= BYTE_SLAVE;
      rw_r       <= 1'b0;
      top_r      <= 1'b0;
      wp_lat_r   <= 1'b0;
      wrote_r    <= 1'b0;
      mack_r     <= 1'b0;
      oe_r       <= 1'b0;
      match_r    <= 1'b0;
      txr_r      <= 1'b0;
      prog_r     <= 1'b0;
      rej_r      <= 1'b0;
      sda_o_r    <= 1'b0;
    end else begin
      pu_cnt_r   <= pu_cnt_nxt;
      ready_r    <= ready_nxt;
      prog_cnt_r <= prog_cnt_nxt;
      busy_r     <= busy_nxt;
      st_r       <= st_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      sh_r       <= sh_nxt;
      byte_idx_r <= byte_idx_nxt;
      rw_r       <= rw_nxt;
      top_r      <= top_nxt;
      wp_lat_r   <= wp_lat_nxt;
      wrote_r    <= wrote_nxt;
      mack_r     <= mack_nxt;
      oe_r       <= oe_nxt;
      match_r    <= match_nxt;
      txr_r      <= txr_nxt;
      prog_r     <= go_prog;
      rej_r      <= rej_nxt;
      sda_o_r    <= 1'b0; // Pin only ever pulled low [RQ6]
    end
  end

  // ----------------------------------------
  // Received byte buffer
  // ----------------------------------------
  sef_fifo #(
    .WIDTH (RX_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_wr_valid (fifo_push),
    .i_wr_data  ({byte_idx_r == BYTE_DATA, sh_r}),
    .o_wr_ready (fifo_rdy),
    .o_rd_valid (o_rx_valid),
    .o_rd_data  (o_rx_data),
    .i_rd_ready (i_rx_ready)
  );

  assign o_sda_o                  = sda_o_r;
  assign o_sda_oe                 = oe_r;
  assign o_ready                  = ready_r;
  assign o_busy                   = busy_r;
  assign o_addr_match             = match_r;
  assign o_read_mode              = rw_r;
  assign o_memory_address_top_bit = top_r;
  assign o_tx_req                 = txr_r;
  assign o_prog_start             = prog_r;
  assign o_wp_reject              = rej_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_addr_done;
    st_r == S_RECV && byte_idx_r == BYTE_SLAVE && bit_cnt_r == BITS_PER_BYTE && scl_fall;
  endsequence

  sequence s_data_done;
    st_r == S_RECV && byte_idx_r == BYTE_DATA && bit_cnt_r == BITS_PER_BYTE && scl_fall;
  endsequence

  chk_reset_idle: assert property ($past(i_reset) |-> st_r == S_IDLE && !oe_r && !busy_r) // [RQ1] [RQ2]
    else $error("state not idle after reset");
  chk_ready_delay: assert property ($rose(ready_r) |-> $past(pu_cnt_r) == PU_W'(PU_CYC - 1)) // [RQ3]
    else $error("ready at wrong time");
  chk_rx_capture: assert property (st_r == S_RECV && scl_rise && !stop_ev && !start_ev
      |=> sh_r[0] == $past(sda_f)) // [RQ4]
    else $error("bit not captured on rising clock");
  chk_oe_on_fall: assert property ($rose(oe_r) |-> $past(scl_fall)) // [RQ5]
    else $error("data drive began off a falling edge");
  chk_never_high: assert property (oe_r |-> !o_sda_o) // [RQ6]
    else $error("data pin driven high");
  chk_glitch_filter: assert property ($changed(scl_f) |-> $past(scl_s2, 1) == scl_f
      && $past(scl_s2, 2) == scl_f && $past(scl_s2, 3) == scl_f) // [RQ9] [RQ17]
    else $error("short clock pulse passed filter");
  chk_addr_ack: assert property (s_addr_done ##0 (addr_ok && !busy_r && !stop_ev && !start_ev)
      |=> oe_r && st_r == S_ACK ##1 oe_r) // [RQ12] [RQ13]
    else $error("matching address not acknowledged");
  chk_busy_nack: assert property (s_addr_done ##0 busy_r |=> !oe_r && st_r == S_IDLE) // [RQ14]
    else $error("address acknowledged while busy");
  chk_wp_nack: assert property (s_data_done ##0 (wp_lat_r && !stop_ev && !start_ev)
      |=> !oe_r && o_wp_reject) // [RQ15]
    else $error("protected data byte acknowledged");
  chk_wp_noprog: assert property (stop_ev && wp_lat_r |=> !o_prog_start) // [RQ7]
    else $error("protected write started programming");
  chk_prog_time: assert property ($fell(busy_r) |-> $past(prog_cnt_r) == PROG_W'(PROG_CYC - 1)) // [RQ16]
    else $error("program cycle length wrong");

endmodule // sef_front

`default_nettype wire

// ===== verification/sef_master.sv
// Bus master model: drives the serial clock and pulls the data wire.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none

module sef_master #(
  parameter int LO = 12,
  parameter int HI = 4
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ----------------------------------------
  // Bus phases, moved at falling clock edges
  // ----------------------------------------
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Clock rests high outside frames; only this side moves it
  task automatic idle();
    o_sda_oe = 1'b0;
    o_scl    = 1'b1;
  endtask

  task automatic start();
    wait_n(1);
    o_sda_oe = 1'b0;
    wait_n(LO);
    o_scl = 1'b1;
    wait_n(HI);
    o_sda_oe = 1'b1;
    wait_n(HI);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    wait_n(1);
    o_sda_oe = 1'b1;
    wait_n(LO);
    o_scl = 1'b1;
    wait_n(HI);
    o_sda_oe = 1'b0;
    wait_n(HI + 8);
  endtask

  // Low phase is long: the slave answers some cycles after the clock falls
  task automatic bit_cyc(input logic b, input logic glitch, output logic seen);
    wait_n(1);
    o_sda_oe = !b;
    wait_n(3);
    o_scl = glitch;
    wait_n(1);
    o_scl = 1'b0;
    wait_n(LO - 5);
    o_scl = 1'b1;
    wait_n(1);
    o_sda_oe = glitch | !b;
    wait_n(1);
    o_sda_oe = !b;
    wait_n(HI - 3);
    seen = i_sda;
    wait_n(1);
    o_scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, input logic g, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], g && i == 3, s);
    bit_cyc(1'b1, 1'b0, s);
    ack = !s;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, 1'b0, d[i]);
    bit_cyc(!mack, 1'b0, s);
  endtask
endmodule // sef_master

`default_nettype wire

// ===== verification/sef_front_test.sv
// Self-checking bench of the bus front end with a master model.
// Assumes PROG_CYC shortened to 200 cycles and a pull-up on the data wire.
`timescale 1ns/1ns
`default_nettype none

module sef_front_test import sef_pkg::*;;
  // ----------------------------------------
  // Stimulus, monitors and scenarios
  // ----------------------------------------
  localparam int PROG = 200;
  logic clk, reset, wp, sel_lo, sel_hi, rx_ready, scl, m_oe;
  logic sda_o, sda_oe, ready, busy, addr_match, read_mode, top_bit;
  logic tx_req, rx_valid, prog_start, wp_reject, scl_d, oe_d;
  logic [7:0] tx_data;
  logic [RX_W-1:0] rx_data;
  logic [8:0] exp_q[$];
  wire logic sda;
  int mismatches = 0, n_tests = 0, since_rst = 0, addr_cnt = 0, prog_cnt = 0;
  int rej_cnt = 0, busy_cyc = 0, hi_chg = 0, od_bad = 0;

  assign sda = (sda_oe === 1'b1 || m_oe === 1'b1) ? 1'b0 : 1'b1;

  sef_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  sef_front #(.PROG_CYC(PROG)) dut (
    .i_clk                    (clk),
    .i_reset                  (reset),
    .i_scl                    (scl),
    .i_sda                    (sda),
    .o_sda_o                  (sda_o),
    .o_sda_oe                 (sda_oe),
    .i_wp                     (wp),
    .i_device_select_bit_low  (sel_lo),
    .i_device_select_bit_high (sel_hi),
    .o_ready                  (ready),
    .o_busy                   (busy),
    .o_addr_match             (addr_match),
    .o_read_mode              (read_mode),
    .o_memory_address_top_bit (top_bit),
    .o_tx_req                 (tx_req),
    .i_tx_data                (tx_data),
    .o_rx_valid               (rx_valid),
    .o_rx_data                (rx_data),
    .i_rx_ready               (rx_ready),
    .o_prog_start             (prog_start),
    .o_wp_reject              (wp_reject)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  always @(posedge clk) begin
    since_rst <= (reset === 1'b1) ? 0 : since_rst + 1;
    if (addr_match === 1'b1) addr_cnt <= addr_cnt + 1;
    if (prog_start === 1'b1) prog_cnt <= prog_cnt + 1;
    if (wp_reject === 1'b1) rej_cnt <= rej_cnt + 1;
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (reset === 1'b0 && scl === 1'b1 && scl_d === 1'b1 && sda_oe !== oe_d) hi_chg <= hi_chg + 1;
    if (sda_oe === 1'b1 && sda_o !== 1'b0) od_bad <= od_bad + 1;
    scl_d <= scl;
    oe_d  <= sda_oe;
  end

  // Core side: next byte offered once the current one is taken
  always @(negedge clk) if (tx_req === 1'b1) tx_data <= tx_data + 8'h11;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
  endtask

  // Consumer stalls until here, then pops every queued word
  task automatic drain();
    rx_ready = 1'b1;
    // Head is judged before the rising edge that pops it
    for (int i = 0; i < 40 && exp_q.size() > 0; i++) begin
      if (rx_valid === 1'b1) check(rx_data, exp_q.pop_front());
      @(negedge clk);
    end
    rx_ready = 1'b0;
    check(rx_valid, 0);
    check(exp_q.size(), 0);
  endtask

  task automatic byte_write(input logic [7:0] slave, output logic a_dat);
    logic a0, a1, a2;
    m.start();
    m.wbyte(slave, 1'b0, a0);
    m.wbyte(8'h01, 1'b0, a1);
    m.wbyte(8'h02, 1'b0, a2);
    m.wbyte(8'h5a, 1'b0, a_dat);
    m.stop();
    check({a0, a1, a2}, 3'h7);
    exp_q.push_back(9'h001);
    exp_q.push_back(9'h002);
  endtask

  task automatic t_power();
    logic a;
    check({sda_oe, ready, busy, rx_valid}, 4'h0);
    m.start();
    m.wbyte(8'ha0, 1'b0, a);
    m.stop();
    check(a, 0);
    wait_ready();
    check(since_rst >= PU_CYC && since_rst <= PU_CYC + 2, 1);
    $display("t_power done at %0t", $time);
  endtask

  task automatic t_write();
    logic a;
    int p0 = prog_cnt, b0 = busy_cyc, m0 = addr_cnt;
    {sel_hi, sel_lo} = 2'h2;
    m.start();
    m.wbyte(8'haa, 1'b0, a);
    check(a, 1);
    check({addr_cnt - m0 == 1, top_bit, read_mode}, 3'h6);
    for (int i = 0; i < 9; i++) begin
      m.wbyte(8'h30 + 8'(i), 1'b0, a);
      check(a, i < 8);
      if (i < 8) exp_q.push_back({i >= 2, 8'h30 + 8'(i)});
    end
    m.stop();
    m.start();
    m.wbyte(8'haa, 1'b0, a);
    m.stop();
    check(a, 0);
    check(prog_cnt - p0, 1);
    wait_idle();
    check(busy_cyc - b0, PROG);
    drain();
    $display("t_write done at %0t", $time);
  endtask

  task automatic t_select();
    logic a;
    logic [7:0] d, e;
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} = 2'(s);
      wp = s[0];
      m.start();
      m.wbyte({4'ha, 2'(s) ^ 2'h1, 2'h0}, 1'b0, a);
      check(a, 0);
      m.start();
      m.wbyte({4'ha, 2'(s), 2'h1}, 1'b0, a);
      check({a, read_mode, top_bit}, 3'h6);
      for (int k = 0; k < 2; k++) begin
        e = tx_data;
        m.rbyte(k == 0, d);
        check(d, e);
      end
      m.stop();
    end
    check(hi_chg, 0);
    check(od_bad, 0);
    wp = 1'b0;
    $display("t_select done at %0t", $time);
  endtask

  task automatic t_protect();
    logic a;
    int p0 = prog_cnt, r0 = rej_cnt;
    {sel_hi, sel_lo} = 2'h0;
    wp = 1'b1;
    byte_write(8'ha0, a);
    check(a, 0);
    check(rej_cnt - r0, 1);
    check({prog_cnt - p0 == 0, busy}, 2'h2);
    wp = 1'b0;
    drain();
    $display("t_protect done at %0t", $time);
  endtask

  task automatic t_float();
    logic a;
    int p0 = prog_cnt;
    {wp, sel_hi, sel_lo} = 3'bzzz;
    byte_write(8'ha0, a);
    check(a, 1);
    check(prog_cnt - p0, 1);
    exp_q.push_back(9'h15a);
    wait_idle();
    drain();
    {wp, sel_hi, sel_lo} = 3'h0;
    $display("t_float done at %0t", $time);
  endtask

  task automatic t_glitch();
    logic a;
    int p0 = prog_cnt;
    m.start();
    m.wbyte(8'ha0, 1'b0, a);
    m.wbyte(8'h9c, 1'b1, a);
    m.stop();
    check(a, 1);
    check(prog_cnt - p0, 0);
    exp_q.push_back(9'h09c);
    drain();
    $display("t_glitch done at %0t", $time);
  endtask

  task automatic t_abort();
    logic a;
    m.start();
    m.wbyte(8'ha0, 1'b0, a);
    m.bit_cyc(1'b0, 1'b0, a);
    do_reset();
    m.idle();
    check({sda_oe, ready, busy, rx_valid}, 4'h0);
    wait_ready();
    m.start();
    m.wbyte(8'ha0, 1'b0, a);
    m.stop();
    check(a, 1);
    $display("t_abort done at %0t", $time);
  endtask

  initial begin
    {reset, wp, sel_lo, sel_hi, rx_ready} = 5'h10;
    tx_data = 8'hc5;
    do_reset();
    t_power();
    t_write();
    t_select();
    t_protect();
    t_float();
    t_glitch();
    t_abort();
    close_out();
  end

  // Whole run is about 12000 cycles
  initial begin
    repeat (40000) @(negedge clk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // sef_front_test

`default_nettype wire
